// file: gsos_host_pin.sv
// Host-side model of the status input pin: measures pulse widths
`timescale 1ns/10ps
module gsos_host_pin (
  input  wire logic        sys_clk,
  input  wire logic        pin,
  output logic      [15:0] width
);
  logic [15:0] run = 16'h0000;
  initial width = 16'h0000;
  // Count high cycles and latch the length when the pin falls
  always @(posedge sys_clk) begin
    if (pin) run <= run + 16'h0001;
    else begin
      if (run != 16'h0000) width <= run;
      run <= 16'h0000;
    end
  end
endmodule // gsos_host_pin

// file: gsos_pkg.sv
// Package for the status output selector: function codes, timing and carriers
package gsos_pkg;

  // ----------------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] FN_TEMP_SHUTDOWN = 5'h04;
  localparam logic [4:0] FN_ACC_DETECT    = 5'h05;
  localparam logic [4:0] FN_LOOP_A_LOCK   = 5'h09;
  localparam logic [4:0] FN_LOOP_B_LOCK   = 5'h0a;
  localparam logic [4:0] FN_RATE_A_LOCK   = 5'h0b;
  localparam logic [4:0] FN_RATE_B_LOCK   = 5'h0c;
  localparam logic [4:0] FN_RANGE_A_SIG   = 5'h0d;
  localparam logic [4:0] FN_RANGE_B_SIG   = 5'h0f;
  localparam logic [4:0] FN_FIFO_ERROR    = 5'h11;
  localparam logic [4:0] FN_CLOCK_OUT     = 5'h12;
  localparam logic [4:0] FN_TEMP_WARNING  = 5'h13;
  localparam logic [4:0] FN_SERVO_DONE    = 5'h14;
  localparam logic [4:0] FN_RESET         = 5'h00;

  // ----------------------------------------------------------------------
  // Register map (word offsets)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_FUNC     = 4'h0;
  localparam logic [3:0] ADDR_LEVELS   = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLR  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h4;

  // Interrupt status bit positions
  localparam int IRQ_ACC_EVENT = 0;
  localparam int IRQ_OVERTEMP  = 1;
  localparam int IRQ_FIFO_ERR  = 2;
  localparam int IRQ_BITS      = 3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ACC_PULSE_US  = 31;
  localparam int ACC_PULSE_CYC = (ACC_PULSE_US * 1000000) / CLK_PERIOD_PS;

  // Status levels delivered by the surrounding codec logic
  typedef struct packed {
    logic temp_shutdown;
    logic temp_warning;
    logic freq_loop_a_lock;
    logic freq_loop_b_lock;
    logic rate_converter_a_lock;
    logic rate_converter_b_lock;
    logic range_controller_a_sig;
    logic range_controller_b_sig;
    logic fifo_error;
    logic servo_done;
  } gsos_status_s;

endpackage

// file: gsos_pulse.sv
// One-shot pulse stretcher for the accessory-detect output
`timescale 1ns/10ps
module gsos_pulse #(
  parameter int WIDTH_CYC = gsos_pkg::ACC_PULSE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic trigger,
  output logic      pulse
);

  initial begin
    if (WIDTH_CYC < 1 || WIDTH_CYC > 65535) begin
      $error("gsos_pulse: WIDTH_CYC out of range");
    end
  end

  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_pulse;

  // Load on trigger, count down, pulse while nonzero; retrigger restarts
  always_comb begin
    next_count = count;
    if (trigger) begin
      next_count = 16'(WIDTH_CYC);
    end else if (count != 16'h0000) begin
      next_count = count - 16'h0001;
    end
    next_pulse = (next_count != 16'h0000);
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      pulse <= 1'b0;
    end else if (clk_en) begin
      count <= next_count;
      pulse <= next_pulse;
    end
  end

endmodule // gsos_pulse

// file: gsos_select.sv
// Status output selector: routes one internal status signal onto a GPIO pin
// Notes on behaviour
// - Code 05h: one 31 us pulse per accessory insert, removal or impedance change
// - Code 09h: pin shows first frequency loop lock
// - Code 0Ah: pin shows second frequency loop lock
// - Code 0Bh: pin shows first rate converter lock
// - Code 0Ch: pin shows second rate converter lock
// - Code 0Dh: pin shows first interface range controller signal detect
// - Code 0Fh: pin shows second interface range controller signal detect
// - Code 11h: pin shows digital core FIFO error
// - Code 12h: pin carries the clock derived from the system clock
// - Code 13h: pin shows temperature above warning level
// - Code 14h: pin shows headphone DC servo complete
// - Code 04h: pin shows temperature above shutdown level
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
module gsos_select #(
  parameter int PULSE_CYC = gsos_pkg::ACC_PULSE_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic [3:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [31:0]           rdata,
  input  wire gsos_pkg::gsos_status_s status,
  input  wire logic                  accessory_detect,
  input  wire logic                  derived_clock_out,
  output logic                       gpio_out,
  output logic                       gpio_oe,
  output logic                       irq
);

  initial begin
    if (PULSE_CYC < 1) begin
      $error("gsos_select: PULSE_CYC must be at least one");
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [4:0]                    func;
  logic [4:0]                    next_func;
  logic [31:0]                   next_rdata;
  logic [gsos_pkg::IRQ_BITS-1:0] irq_stat;
  logic [gsos_pkg::IRQ_BITS-1:0] next_irq_stat;
  logic [gsos_pkg::IRQ_BITS-1:0] irq_en;
  logic [gsos_pkg::IRQ_BITS-1:0] next_irq_en;
  logic [gsos_pkg::IRQ_BITS-1:0] events;
  logic                          acc_pulse;
  logic                          level_sel;
  logic                          next_level;
  logic                          level_q;
  logic                          shut_q;
  logic                          fifo_q;
  logic                          is_clock;

  // Status packed into a readable word
  function automatic logic [31:0] pack_levels(gsos_pkg::gsos_status_s s);
    return {22'h00_0000, s};
  endfunction

  // ----------------------------------------------------------------------
  // Accessory event pulse
  // ----------------------------------------------------------------------
  gsos_pulse #(
    .WIDTH_CYC (PULSE_CYC)
  ) u_pulse (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .trigger  (accessory_detect),
    .pulse    (acc_pulse)
  );

  // ----------------------------------------------------------------------
  // Function selection
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (func)
      gsos_pkg::FN_TEMP_SHUTDOWN: level_sel = status.temp_shutdown;
      gsos_pkg::FN_ACC_DETECT:    level_sel = acc_pulse;
      gsos_pkg::FN_LOOP_A_LOCK:   level_sel = status.freq_loop_a_lock;
      gsos_pkg::FN_LOOP_B_LOCK:   level_sel = status.freq_loop_b_lock;
      gsos_pkg::FN_RATE_A_LOCK:   level_sel = status.rate_converter_a_lock;
      gsos_pkg::FN_RATE_B_LOCK:   level_sel = status.rate_converter_b_lock;
      gsos_pkg::FN_RANGE_A_SIG:   level_sel = status.range_controller_a_sig;
      gsos_pkg::FN_RANGE_B_SIG:   level_sel = status.range_controller_b_sig;
      gsos_pkg::FN_FIFO_ERROR:    level_sel = status.fifo_error;
      gsos_pkg::FN_TEMP_WARNING:  level_sel = status.temp_warning;
      gsos_pkg::FN_SERVO_DONE:    level_sel = status.servo_done;
      default:                    level_sel = 1'b0;
    endcase
    next_level = level_sel;
  end

  // Clock passes combinationally so it is not halved by registering
  assign is_clock = (func == gsos_pkg::FN_CLOCK_OUT);
  assign gpio_out = is_clock ? derived_clock_out : level_q;
  assign gpio_oe  = 1'b1;

  // ----------------------------------------------------------------------
  // Register file and interrupts
  // ----------------------------------------------------------------------
  assign events = {status.fifo_error & ~fifo_q,
                   status.temp_shutdown & ~shut_q,
                   accessory_detect};

  always_comb begin
    next_func     = func;
    next_irq_en   = irq_en;
    next_irq_stat = irq_stat;
    next_rdata    = 32'h0000_0000;
    if (wr && addr == gsos_pkg::ADDR_FUNC) begin
      next_func = wdata[4:0];
    end
    if (wr && addr == gsos_pkg::ADDR_IRQ_EN) begin
      next_irq_en = wdata[gsos_pkg::IRQ_BITS-1:0];
    end
    if (wr && addr == gsos_pkg::ADDR_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~wdata[gsos_pkg::IRQ_BITS-1:0];
    end
    // Set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | events;
    if (rd) begin
      unique case (addr)
        gsos_pkg::ADDR_FUNC:     next_rdata = {27'h000_0000, func};
        gsos_pkg::ADDR_LEVELS:   next_rdata = pack_levels(status);
        gsos_pkg::ADDR_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
        gsos_pkg::ADDR_IRQ_EN:   next_rdata = {29'h0000_0000, irq_en};
        default:                 next_rdata = 32'h0000_0000;
      endcase
    end
  end

  assign irq = |(irq_stat & irq_en);

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      func     <= gsos_pkg::FN_RESET;
      rdata    <= 32'h0000_0000;
      irq_stat <= '0;
      irq_en   <= '0;
      level_q  <= 1'b0;
      shut_q   <= 1'b0;
      fifo_q   <= 1'b0;
    end else if (clk_en) begin
      func     <= next_func;
      rdata    <= next_rdata;
      irq_stat <= next_irq_stat;
      irq_en   <= next_irq_en;
      level_q  <= next_level;
      shut_q   <= status.temp_shutdown;
      fifo_q   <= status.fifo_error;
    end
  end

endmodule // gsos_select

// file: gsos_select_checker.sv
// Assertion checker for the status output selector
`timescale 1ns/10ps
module gsos_select_checker #(
  parameter int PULSE_CYC = gsos_pkg::ACC_PULSE_CYC
) (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  input wire logic [3:0]            addr,
  input wire logic [31:0]           wdata,
  input wire logic                  wr,
  input wire logic                  rd,
  input wire logic [31:0]           rdata,
  input wire gsos_pkg::gsos_status_s status,
  input wire logic                  accessory_detect,
  input wire logic                  derived_clock_out,
  input wire logic                  gpio_out,
  input wire logic                  gpio_oe,
  input wire logic                  irq
);
  logic [4:0]  fn;
  logic [15:0] pcnt;
  logic [2:0]  en_m;
  // Mirror of the function code, interrupt enables and accessory pulse countdown
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fn   <= 5'h00;
      pcnt <= 16'h0000;
      en_m <= 3'h0;
    end else if (clk_en) begin
      if (wr && addr == 4'h0) fn <= wdata[4:0];
      if (wr && addr == 4'h4) en_m <= wdata[2:0];
      if (accessory_detect) pcnt <= 16'(PULSE_CYC);
      else if (pcnt != 16'h0000) pcnt <= pcnt - 16'h0001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Pin shows the selected level one cycle later
  property p(logic [4:0] c, logic s);
    $past(clk_en) && $past(fn) == c |-> gpio_out == $past(s);
  endproperty
  a_pin_tshut: assert property (p(5'h04, status.temp_shutdown)) else $error("Pin shutdown");
  a_pin_lka: assert property (p(5'h09, status.freq_loop_a_lock)) else $error("Pin loop a");
  a_pin_lkb: assert property (p(5'h0a, status.freq_loop_b_lock)) else $error("Pin loop b");
  a_pin_rca: assert property (p(5'h0b, status.rate_converter_a_lock)) else $error("Pin rate a");
  a_pin_rcb: assert property (p(5'h0c, status.rate_converter_b_lock)) else $error("Pin rate b");
  a_pin_rga: assert property (p(5'h0d, status.range_controller_a_sig)) else $error("Pin range a");
  a_pin_rgb: assert property (p(5'h0f, status.range_controller_b_sig)) else $error("Pin range b");
  a_pin_fifo: assert property (p(5'h11, status.fifo_error)) else $error("Pin fifo");
  a_pin_twarn: assert property (p(5'h13, status.temp_warning)) else $error("Pin warning");
  a_pin_servo: assert property (p(5'h14, status.servo_done)) else $error("Pin servo");
  a_clock_pass: assert property (fn == 5'h12 |-> gpio_out == derived_clock_out) else $error("Pin clock");
  // The pin is one flop behind the pulse stretcher, so it follows last cycle's countdown
  a_acc_pulse: assert property ($past(clk_en) && $past(fn) == 5'h05 |-> gpio_out == ($past(pcnt) != 16'h0000))
    else $error("Pin pulse");
  a_reserved_low: assert property ($past(clk_en) && $past(fn) inside {5'h00, 5'h06, 5'h07, 5'h08, 5'h0e, 5'h10,
    [5'h15:5'h1f]} |-> !gpio_out) else $error("Pin reserved");
  a_oe_high: assert property (gpio_oe) else $error("Pin not driven");
  a_irq_masked: assert property (en_m == 3'h0 |-> !irq) else $error("Interrupt while masked");
  a_rdata_idle: assert property ($past(clk_en) && !$past(rd) |-> rdata == 32'h0000_0000)
    else $error("Read data outside read cycle");
  a_code_read: assert property (clk_en && rd && addr == 4'h0 |=> rdata == {27'h0, $past(fn)})
    else $error("Code readback");
  cover property ($rose(gpio_out) && fn == 5'h05);
  cover property (fn == 5'h12 && $changed(gpio_out));
  cover property (rd && addr == 4'h0);
endmodule // gsos_select_checker

bind gsos_select gsos_select_checker #(.PULSE_CYC(PULSE_CYC)) i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .status(status),
  .accessory_detect(accessory_detect), .derived_clock_out(derived_clock_out), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .irq(irq));

// file: tb_top.sv
// Self-checking testbench for the status output selector
`timescale 1ns/10ps
module tb_top;
  logic                   sys_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   clk_en = 1'b1;
  logic                   gpio_oe;
  logic [3:0]             addr = 4'h0;
  logic [31:0]            wdata = 32'h0000_0000;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [31:0]            rdata;
  gsos_pkg::gsos_status_s status = '0;
  logic                   acc = 1'b0;
  logic                   dclk = 1'b0;
  logic                   gpio_out;
  logic                   irq;
  logic [15:0]            width;
  logic [31:0]            rv;
  int                     n_fail = 0;
  int                     checks_done = 0;
  int                     cyc = 0;
  // Accessory pulse length: 31 us at a 10 ns clock
  localparam int          PULSE_EXP = 31 * 1000 / 10;

  gsos_select i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .status(status), .accessory_detect(acc),
    .derived_clock_out(dclk), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq(irq));
  gsos_host_pin i_host (.sys_clk(sys_clk), .pin(gpio_out), .width(width));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask

  // Each level code routes only its own status bit
  task automatic test_levels();
    logic [4:0] c [10] = '{5'h04, 5'h13, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0f, 5'h11, 5'h14};
    for (int i = 0; i < 10; i++) begin
      wr_reg(4'h0, {27'h0, c[i]});
      status <= ~(10'h200 >> i);
      repeat (2) @(posedge sys_clk);
      chk("level low", {31'h0, gpio_out}, 32'h0000_0000);
      status <= 10'h200 >> i;
      repeat (2) @(posedge sys_clk);
      chk("level high", {31'h0, gpio_out}, 32'h0000_0001);
    end
  endtask

  // Reset code reads back as zero and reserved codes hold the pin low
  task automatic test_reserved();
    logic [4:0] c [7] = '{5'h06, 5'h07, 5'h08, 5'h0e, 5'h10, 5'h15, 5'h1f};
    rd_reg(4'h0, rv);
    chk("reset code", rv, 32'h0000_0000);
    chk("output enable", {31'h0, gpio_oe}, 32'h0000_0001);
    status <= 10'h3ff;
    for (int i = 0; i < 7; i++) begin
      wr_reg(4'h0, {27'h0, c[i]});
      repeat (2) @(posedge sys_clk);
      chk("reserved", {31'h0, gpio_out}, 32'h0000_0000);
    end
    // Rising shutdown and FIFO error flags latch their status bits
    rd_reg(4'h1, rv);
    chk("levels", rv, 32'h0000_03ff);
    rd_reg(4'h2, rv);
    chk("irq status", rv, 32'h0000_0006);
    wr_reg(4'h3, 32'h0000_0006);
    rd_reg(4'h2, rv);
    chk("irq status cleared", rv, 32'h0000_0000);
  endtask

  // Clock enable low freezes the pin and ignores writes
  task automatic test_freeze();
    wr_reg(4'h0, 32'h0000_0009);
    status <= 10'h080;
    repeat (2) @(posedge sys_clk);
    clk_en <= 1'b0;
    status <= 10'h000;
    wr_reg(4'h0, 32'h0000_0004);
    chk("frozen pin", {31'h0, gpio_out}, 32'h0000_0001);
    clk_en <= 1'b1;
    rd_reg(4'h0, rv);
    chk("frozen code", rv, 32'h0000_0009);
  endtask

  // Accessory pulse width, interrupt raise, clear and mask
  task automatic test_pulse();
    wr_reg(4'h4, 32'h0000_0001);
    wr_reg(4'h0, 32'h0000_0005);
    for (int k = 0; k < 2; k++) begin
      acc <= 1'b1;
      @(posedge sys_clk);
      acc <= 1'b0;
      repeat (PULSE_EXP + 4) @(posedge sys_clk);
      chk("pulse width", {16'h0, width}, 32'(PULSE_EXP));
      chk("irq", {31'h0, irq}, {31'h0, k == 0});
      wr_reg(4'h3, 32'h0000_0001);
      chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
      wr_reg(4'h4, 32'h0000_0000);
    end
  endtask

  // Derived clock passes straight to the pin
  task automatic test_clock();
    wr_reg(4'h0, 32'h0000_0012);
    for (int i = 0; i < 4; i++) begin
      dclk <= ~dclk;
      #1;
      chk("clock out", {31'h0, gpio_out}, {31'h0, dclk});
      @(posedge sys_clk);
    end
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_reserved();
    test_levels();
    test_freeze();
    test_pulse();
    test_clock();
    complete_run();
  end
endmodule // tb_top
